// ### hw/rwf_pkg.sv
package rwf_pkg;
	// apb byte addresses
	localparam logic [7:0] RWF_OFF_MAC_CONTROL = 8'h00;
	localparam logic [7:0] RWF_OFF_ADDR_HIGH = 8'h04;
	localparam logic [7:0] RWF_OFF_ADDR_LOW = 8'h08;
	localparam logic [7:0] RWF_OFF_HASH_HIGH = 8'h0c;
	localparam logic [7:0] RWF_OFF_HASH_LOW = 8'h10;
	localparam logic [7:0] RWF_OFF_WAKE_CSR = 8'h14;
	localparam logic [7:0] RWF_OFF_WAKE_FILTER = 8'h18;
	// mac_control fields
	localparam int RWF_MC_HASH_PERFECT = 0;
	localparam int RWF_MC_HASH_ONLY = 1;
	localparam int RWF_MC_INVERSE = 2;
	localparam int RWF_MC_PROMISC = 3;
	localparam int RWF_MC_PASS_MCAST = 4;
	localparam int RWF_MC_BROADCAST_DISABLE_DIS = 5;
	localparam logic [5:0] RWF_MC_RESET = 6'h00;
	// wake_control_status fields
	localparam int RWF_WC_ENABLE = 0;
	localparam int RWF_WC_RECEIVED = 1;
	localparam int RWF_WC_IRQ_EN = 2;
	localparam int RWF_WC_PME_EN = 3;
	localparam int RWF_WC_LOW_POWER = 4;
	localparam logic [4:0] RWF_WC_RESET = 5'h00;
	// wake filter load layout
	localparam int RWF_NUM_FILTERS = 4;
	localparam int RWF_MASK_W = 31;
	localparam int RWF_LOAD_WORDS = 8;
	localparam int RWF_W_CMD = 4;
	localparam int RWF_W_OFFSET = 5;
	localparam int RWF_W_CRC01 = 6;
	localparam int RWF_W_CRC23 = 7;
	localparam int RWF_CMD_ENABLE = 0;
	localparam int RWF_CMD_MCAST = 3;
	// frame layout and crc constants
	localparam int RWF_DA_BYTES = 6;
	localparam logic [10:0] RWF_CNT_MAX = 11'h7ff;
	localparam logic [31:0] RWF_CRC32_POLY = 32'hedb88320;
	localparam logic [31:0] RWF_CRC32_INIT = 32'hffffffff;
	localparam logic [15:0] RWF_CRC16_POLY = 16'ha001;
	localparam logic [15:0] RWF_CRC16_INIT = 16'hffff;

	typedef struct packed {
		logic sof;
		logic eof;
		logic [7:0] data;
	} rwf_rx_beat_t;

	typedef struct packed {
		logic [15:0] hi;
		logic [31:0] lo;
	} rwf_station_t;
endpackage

// ### hw/rwf_filter.sv
// Behaviour
// RQ1 - first DA bit marks multicast class
// RQ2 - frames failing the filter are dropped
// RQ3 - all bits clear: perfect match only
// RQ4 - hash-perfect: unicast exact, multicast hashed
// RQ5 - both hash bits: hash every address
// RQ6 - inverse: accept only non-matching destinations
// RQ7 - promiscuous accepts everything, broadcasts too
// RQ8 - pass-all-multicast accepts every multicast frame; the code lets inverse mode and broadcast disable take precedence over it
// RQ9 - station address is high:low concatenation
// RQ10 - upper six crc bits index hash
// RQ11 - index msb picks high or low word
// RQ12 - wake enable stops normal reception
// RQ13 - wake frame sets flag, irq or pme
// RQ14 - four filters, address and crc checked
// RQ15 - 31-bit mask selects bytes from offset
// RQ16 - host keeps pattern offset above 12
// RQ17 - host loads filters with eight writes
// RQ18 - load order: masks, commands, offsets, crcs
// RQ19 - wake detection in d0 needs enable
// RQ20 - low-power state forces wake detection on
// RQ21 - broadcast wake frames ignore broadcast disable
// RQ22 - command bit0 enables, bit3 selects multicast
// RQ23 - expected crc-16 compared with computed crc
// RQ24 - hash crc is ethernet crc-32 over DA
// RQ25 - crc-16 per filter, checked at last byte
`timescale 1ns/1ps
`default_nettype none
module rwf_filter
	import rwf_pkg::*;
#(
	parameter int NUM_FILTERS = RWF_NUM_FILTERS,
	parameter int MASK_W = RWF_MASK_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire rwf_rx_beat_t rx_beat,
	output logic rx_accept_valid,
	output logic rx_accept,
	output logic wake_detect,
	output logic irq_out,
	output logic power_event_out
);
	if (NUM_FILTERS != RWF_NUM_FILTERS || MASK_W != RWF_MASK_W) begin : g_bad_param
		$error("rwf_filter: filter count and mask width are fixed by the load layout");
	end

	function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ RWF_CRC32_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ RWF_CRC16_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [4:0] last_set(input logic [30:0] m);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 31; i++) begin
			if (m[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// register state
	logic [5:0] mac_control_reg;
	logic [15:0] addr_high_reg;
	logic [31:0] addr_low_reg;
	logic [31:0] hash_high_reg;
	logic [31:0] hash_low_reg;
	logic [4:0] wake_control_status_reg;
	logic [31:0] wake_frame_filter_mem [RWF_LOAD_WORDS];
	logic [2:0] wff_wptr_reg;
	logic [2:0] wff_rptr_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	// apb decode
	wire setup_phase = psel && !penable;
	wire access_done = psel && penable;
	wire wr_done = access_done && pwrite;
	wire rd_done = access_done && !pwrite;
	wire sel_mc = (paddr == RWF_OFF_MAC_CONTROL);
	wire sel_ah = (paddr == RWF_OFF_ADDR_HIGH);
	wire sel_al = (paddr == RWF_OFF_ADDR_LOW);
	wire sel_hh = (paddr == RWF_OFF_HASH_HIGH);
	wire sel_hl = (paddr == RWF_OFF_HASH_LOW);
	wire sel_wc = (paddr == RWF_OFF_WAKE_CSR);
	wire sel_wf = (paddr == RWF_OFF_WAKE_FILTER);
	wire mapped = sel_mc | sel_ah | sel_al | sel_hh | sel_hl | sel_wc | sel_wf;
	wire [31:0] rd_mux = sel_mc ? {26'h0000000, mac_control_reg} :
		sel_ah ? {16'h0000, addr_high_reg} :
		sel_al ? addr_low_reg :
		sel_hh ? hash_high_reg :
		sel_hl ? hash_low_reg :
		sel_wc ? {27'h0000000, wake_control_status_reg} :
		sel_wf ? wake_frame_filter_mem[wff_rptr_reg] : 32'h00000000;

	assign pready = access_done;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg && access_done;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_reg <= !mapped;
		end
	end

	// control bits
	wire hash_perfect_sel = mac_control_reg[RWF_MC_HASH_PERFECT];
	wire hash_only_sel = mac_control_reg[RWF_MC_HASH_ONLY];
	wire inverse_filter_en = mac_control_reg[RWF_MC_INVERSE];
	wire promiscuous_en = mac_control_reg[RWF_MC_PROMISC];
	wire pass_all_multicast = mac_control_reg[RWF_MC_PASS_MCAST];
	wire broadcast_disable = mac_control_reg[RWF_MC_BROADCAST_DISABLE_DIS];
	wire wake_frame_en = wake_control_status_reg[RWF_WC_ENABLE];
	wire wake_frame_received = wake_control_status_reg[RWF_WC_RECEIVED];
	wire low_power = wake_control_status_reg[RWF_WC_LOW_POWER];
	// RQ19 d0 needs enable
	// RQ20 low power forces detection
	wire wake_active = wake_frame_en || low_power;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_control_reg <= RWF_MC_RESET;
			addr_high_reg <= 16'h0000;
			addr_low_reg <= 32'h00000000;
			hash_high_reg <= 32'h00000000;
			hash_low_reg <= 32'h00000000;
		end else if (wr_done) begin
			if (sel_mc) mac_control_reg <= pwdata[5:0];
			if (sel_ah) addr_high_reg <= pwdata[15:0];
			if (sel_al) addr_low_reg <= pwdata;
			if (sel_hh) hash_high_reg <= pwdata;
			if (sel_hl) hash_low_reg <= pwdata;
		end
	end

	// RQ17 eight sequential loads
	// RQ18 slot order by pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wff_wptr_reg <= 3'h0;
			wff_rptr_reg <= 3'h0;
		end else begin
			if (wr_done && sel_wf) wff_wptr_reg <= wff_wptr_reg + 3'h1;
			if (rd_done && sel_wf) wff_rptr_reg <= wff_rptr_reg + 3'h1;
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_done && sel_wf) wake_frame_filter_mem[wff_wptr_reg] <= pwdata;
	end

	// receive byte tracking
	logic [10:0] byte_cnt_reg;
	logic [47:0] da_reg;
	logic [31:0] hcrc_reg;
	wire [10:0] byte_idx = rx_beat.sof ? 11'h000 : byte_cnt_reg;
	wire [47:0] da_base = rx_beat.sof ? 48'h000000000000 : da_reg;
	wire [31:0] hcrc_base = rx_beat.sof ? RWF_CRC32_INIT : hcrc_reg;
	wire in_da = rx_valid && (byte_idx < 11'(RWF_DA_BYTES));
	wire [2:0] da_pos = byte_idx[2:0];
	logic [47:0] da_next;
	always_comb begin
		da_next = da_base;
		if (in_da) da_next[8*da_pos +: 8] = rx_beat.data;
	end
	// RQ24 crc-32 over DA
	wire [31:0] hcrc_next = in_da ? crc32_byte(hcrc_base, rx_beat.data) : hcrc_base;
	wire addr_done = rx_valid && (byte_idx == 11'(RWF_DA_BYTES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_cnt_reg <= 11'h000;
			da_reg <= 48'h000000000000;
			hcrc_reg <= RWF_CRC32_INIT;
		end else if (rx_valid) begin
			byte_cnt_reg <= (byte_idx == RWF_CNT_MAX) ? RWF_CNT_MAX : byte_idx + 11'h001;
			da_reg <= da_next;
			hcrc_reg <= hcrc_next;
		end
	end

	// address decision
	rwf_station_t station;
	// RQ9 station concatenation
	assign station = '{hi: addr_high_reg, lo: addr_low_reg};
	// RQ1 class bit
	wire da_mcast = da_next[0];
	wire da_broadcast_disable = (da_next == 48'hffffffffffff);
	wire perfect_hit = (da_next == station);
	wire [31:0] hcrc_final = ~hcrc_next;
	// RQ10 upper six crc bits
	wire [5:0] hash_idx = hcrc_final[31:26];
	// RQ11 msb selects word
	wire hash_hit = hash_idx[5] ? hash_high_reg[hash_idx[4:0]] : hash_low_reg[hash_idx[4:0]];
	// RQ3 RQ4 RQ5 RQ6 RQ7 RQ8 mode selection
	wire mode_hit = promiscuous_en ? 1'b1 :
		inverse_filter_en ? !perfect_hit :
		(pass_all_multicast && da_mcast) ? 1'b1 :
		(hash_only_sel && hash_perfect_sel) ? hash_hit :
		(hash_perfect_sel && da_mcast) ? hash_hit : perfect_hit;
	wire broadcast_disable_block = broadcast_disable && da_broadcast_disable && !promiscuous_en;
	// RQ2 RQ12 drop on failure or in wake mode
	wire accept_next = mode_hit && !broadcast_disable_block && !wake_active;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_accept_valid <= 1'b0;
			rx_accept <= 1'b0;
		end else begin
			rx_accept_valid <= addr_done;
			if (addr_done) rx_accept <= accept_next;
		end
	end

	// wake filters
	wire [31:0] cmd_word = wake_frame_filter_mem[RWF_W_CMD];
	wire [31:0] off_word = wake_frame_filter_mem[RWF_W_OFFSET];
	wire [63:0] crc_words = {wake_frame_filter_mem[RWF_W_CRC23], wake_frame_filter_mem[RWF_W_CRC01]};
	wire da_mcast_q = da_reg[0];
	wire perfect_q = (da_reg == station);
	logic [NUM_FILTERS-1:0] filt_hit;

	for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filt
		logic [15:0] crc_reg;
		wire [30:0] mask = wake_frame_filter_mem[f][30:0];
		wire [7:0] cmd = cmd_word[8*f +: 8];
		wire [7:0] offset = off_word[8*f +: 8];
		wire [15:0] expect_crc = crc_words[16*f +: 16];
		wire [10:0] rel = byte_idx - {3'h0, offset};
		wire in_win = rx_valid && (byte_idx >= {3'h0, offset}) && (rel < 11'(MASK_W));
		// RQ15 mask bit j selects offset+j
		wire take = in_win && mask[rel[4:0]];
		wire [15:0] crc_base = rx_beat.sof ? RWF_CRC16_INIT : crc_reg;
		// RQ25 per-filter crc-16
		wire [15:0] crc_next = take ? crc16_byte(crc_base, rx_beat.data) : crc_base;
		wire last = take && (rel[4:0] == last_set(mask));
		// RQ22 enable and address type
		wire type_ok = cmd[RWF_CMD_MCAST] ? da_mcast_q : (!da_mcast_q && perfect_q);
		// RQ23 crc equality
		// RQ14 address and crc both pass
		assign filt_hit[f] = wake_active && cmd[RWF_CMD_ENABLE] && type_ok && last
			&& (crc_next == expect_crc);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				crc_reg <= RWF_CRC16_INIT;
			end else if (rx_valid) begin
				crc_reg <= crc_next;
			end
		end
	end

	// RQ21 broadcast disable not consulted here
	wire wake_hit_any = |filt_hit;
	wire wc_wr = wr_done && sel_wc;

	// RQ13 sticky flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_control_status_reg <= RWF_WC_RESET;
			wake_detect <= 1'b0;
		end else begin
			wake_detect <= wake_hit_any;
			if (wc_wr) begin
				wake_control_status_reg[RWF_WC_ENABLE] <= pwdata[RWF_WC_ENABLE];
				wake_control_status_reg[RWF_WC_IRQ_EN] <= pwdata[RWF_WC_IRQ_EN];
				wake_control_status_reg[RWF_WC_PME_EN] <= pwdata[RWF_WC_PME_EN];
				wake_control_status_reg[RWF_WC_LOW_POWER] <= pwdata[RWF_WC_LOW_POWER];
			end
			if (wake_hit_any) begin
				wake_control_status_reg[RWF_WC_RECEIVED] <= 1'b1;
			end else if (wc_wr && pwdata[RWF_WC_RECEIVED]) begin
				wake_control_status_reg[RWF_WC_RECEIVED] <= 1'b0;
			end
		end
	end

	// RQ13 notification outputs
	assign irq_out = wake_frame_received && wake_control_status_reg[RWF_WC_IRQ_EN];
	assign power_event_out = wake_frame_received && wake_control_status_reg[RWF_WC_PME_EN];

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_hit;
		wake_hit_any;
	endsequence

	property p_write_lands;
		s_setup ##1 (wr_done && sel_al) |=> addr_low_reg == $past(pwdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("station write lost"); // RQ9

	property p_wake_blocks;
		addr_done && wake_active |=> rx_accept_valid && !rx_accept;
	endproperty
	a_wake_blocks: assert property (p_wake_blocks) else $error("frame accepted in wake mode"); // RQ12

	property p_promisc;
		addr_done && promiscuous_en && !wake_active |=> rx_accept;
	endproperty
	a_promisc: assert property (p_promisc) else $error("promiscuous frame dropped"); // RQ7

	property p_perfect;
		addr_done && (mac_control_reg == 6'h00) && !wake_active && (da_next != station)
			|=> !rx_accept;
	endproperty
	a_perfect: assert property (p_perfect) else $error("mismatched address accepted"); // RQ3

	property p_inverse;
		addr_done && inverse_filter_en && !promiscuous_en && !wake_active && perfect_hit
			|=> !rx_accept;
	endproperty
	a_inverse: assert property (p_inverse) else $error("inverse filter passed own address"); // RQ6

	property p_mcast_pass;
		addr_done && pass_all_multicast && da_mcast && !inverse_filter_en && !broadcast_disable_block
			&& !wake_active |=> rx_accept;
	endproperty
	a_mcast_pass: assert property (p_mcast_pass) else $error("multicast frame dropped"); // RQ8

	property p_wake_flag;
		s_hit |=> wake_frame_received && wake_detect;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set"); // RQ13

	property p_wake_irq;
		s_hit ##0 (wake_control_status_reg[RWF_WC_IRQ_EN] && !wc_wr) |=> irq_out;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake irq missing"); // RQ13

	property p_load_ptr;
		wr_done && sel_wf |=> wff_wptr_reg == $past(wff_wptr_reg) + 3'h1;
	endproperty
	a_load_ptr: assert property (p_load_ptr) else $error("filter load pointer stuck"); // RQ18

	property p_no_wake_idle;
		!wake_active |-> !wake_hit_any;
	endproperty
	a_no_wake_idle: assert property (p_no_wake_idle) else $error("wake hit while inactive"); // RQ19
endmodule
`default_nettype wire

// ### verification/rwf_rx_src.sv
`timescale 1ns/1ps
`default_nettype none
module rwf_rx_src
	import rwf_pkg::*;
(
	input wire logic pclk,
	output logic rx_valid,
	output var rwf_rx_beat_t rx_beat
);
	initial begin
		rx_valid = 1'b0;
		rx_beat = '0;
	end
	// one byte a beat, sof on the first, idle gaps when slow
	task automatic send(input logic [7:0] fr[$], input bit slow);
		for (int i = 0; i < fr.size(); i++) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_beat <= '{sof: i == 0, eof: i == fr.size() - 1, data: fr[i]};
			if (slow && i[0]) begin
				@(posedge pclk);
				rx_valid <= 1'b0;
				rx_beat.data <= ~fr[i];
			end
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_beat <= '{sof: 1'b0, eof: 1'b0, data: ~fr[fr.size() - 1]};
	endtask
endmodule
`default_nettype wire

// ### verification/rx_address_and_wakeup_filter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rx_address_and_wakeup_filter_tb_top
	import rwf_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_valid;
	rwf_rx_beat_t rx_beat;
	logic rx_accept_valid;
	logic rx_accept;
	logic wake_detect;
	logic irq_out;
	logic power_event_out;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	int wk_n = 0;
	integer seed = 32'h7745;
	logic acc_q[$];
	logic [7:0] fr[$];
	logic [7:0] pf[$];
	logic [47:0] st;
	logic [47:0] da;
	logic [63:0] ht;
	logic [31:0] rd;
	logic er;
	logic [31:0] wl[8];
	logic [5:0] modes[10] = '{6'h00, 6'h01, 6'h03, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h13, 6'h20};

	always #5 pclk = ~pclk;

	rwf_filter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_beat(rx_beat),
		.rx_accept_valid(rx_accept_valid), .rx_accept(rx_accept), .wake_detect(wake_detect),
		.irq_out(irq_out), .power_event_out(power_event_out));
	rwf_rx_src src_u (.pclk(pclk), .rx_valid(rx_valid), .rx_beat(rx_beat));

	always @(posedge pclk) begin
		cyc++;
		if (rx_accept_valid === 1'b1) acc_q.push_back(rx_accept);
		if (wake_detect === 1'b1) wk_n++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [15:0] crc16(logic [7:0] b[$]);
		logic [15:0] c;
		c = RWF_CRC16_INIT;
		foreach (b[i]) for (int j = 0; j < 8; j++)
			c = (c[0] ^ b[i][j]) ? (c >> 1) ^ RWF_CRC16_POLY : c >> 1;
		return c;
	endfunction

	function automatic logic exp_acc(logic [5:0] mc, logic [47:0] d);
		logic [31:0] c;
		c = RWF_CRC32_INIT;
		for (int i = 0; i < 48; i++)
			c = (c[0] ^ d[i]) ? (c >> 1) ^ RWF_CRC32_POLY : c >> 1;
		c = ~c;
		if (mc[RWF_MC_PROMISC]) return 1'b1;
		if (mc[RWF_MC_BROADCAST_DISABLE_DIS] && &d) return 1'b0;
		if (mc[RWF_MC_INVERSE]) return d != st;
		if (mc[RWF_MC_PASS_MCAST] && d[0]) return 1'b1;
		if (mc[RWF_MC_HASH_ONLY] && mc[RWF_MC_HASH_PERFECT]) return ht[c[31:26]];
		if (mc[RWF_MC_HASH_PERFECT] && d[0]) return ht[c[31:26]];
		return d == st;
	endfunction

	task automatic go(input logic [47:0] d, input bit slow);
		fr = pf;
		for (int k = 0; k < 6; k++) fr[k] = d[8*k +: 8];
		acc_q.delete();
		wk_n = 0;
		src_u.send(fr, slow);
		repeat (3) @(posedge pclk);
	endtask

	task automatic wake_frame(input logic [47:0] d, input int n);
		go(d, 1'b0);
		chk("wake_detect count", n, wk_n);
		while (acc_q.size() > 0) chk("wake mode accept", 0, acc_q.pop_front());
	endtask

	initial begin
		repeat (24) pf.push_back(8'($random(seed)));
		st = {16'($random(seed)), 32'($random(seed))};
		st[0] = 1'b0;
		ht = {32'($random(seed)), 32'($random(seed))};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, RWF_OFF_MAC_CONTROL, 0);
		chk("mac_control reset", 0, rd);
		apb(1'b0, 8'h1c, 0);
		chk("unmapped pslverr", 1, er);
		apb(1'b1, RWF_OFF_HASH_HIGH, ht[63:32]);
		apb(1'b1, RWF_OFF_HASH_LOW, ht[31:0]);
		apb(1'b1, RWF_OFF_ADDR_HIGH, {16'h0000, st[47:32]});
		apb(1'b1, RWF_OFF_ADDR_LOW, st[31:0]);
		foreach (modes[m]) begin
			apb(1'b1, RWF_OFF_MAC_CONTROL, {26'h0, modes[m]});
			for (int k = 0; k < 6; k++) begin
				case (k)
					0: da = st;
					1: da = st ^ 48'h0000_0010_0000;
					2: da = {16'($random(seed)), 32'($random(seed))} | 48'h1;
					3: da = '1;
					4: da = {16'($random(seed)), 32'($random(seed))} & ~48'h1;
					default: da = st | 48'h1;
				endcase
				go(da, 1'($random(seed)));
				chk("decision count", 1, acc_q.size());
				chk("rx_accept", exp_acc(modes[m], da), acc_q[0]);
			end
		end
		wl = '{32'h7, 32'h11, 0, 0, 32'h0901, 32'h0d0e, 0, 0};
		wl[6] = {crc16('{pf[13], pf[17]}), crc16('{pf[14], pf[15], pf[16]})};
		apb(1'b1, RWF_OFF_MAC_CONTROL, 32'h20);
		foreach (wl[i]) apb(1'b1, RWF_OFF_WAKE_FILTER, wl[i]);
		apb(1'b1, RWF_OFF_WAKE_CSR, 32'h5);
		wake_frame(st, 1);
		apb(1'b0, RWF_OFF_WAKE_CSR, 0);
		chk("wake_frame_received", 1, rd[RWF_WC_RECEIVED]);
		chk("irq_out", 1, irq_out);
		apb(1'b1, RWF_OFF_WAKE_CSR, 32'h7);
		chk("irq_out cleared", 0, irq_out);
		pf[15] = ~pf[15];
		wake_frame(st, 0);
		pf[15] = ~pf[15];
		wake_frame(st | 48'h1, 1);
		pf[13] = ~pf[13];
		wake_frame(st | 48'h1, 0);
		pf[13] = ~pf[13];
		wake_frame('1, 1);
		apb(1'b1, RWF_OFF_WAKE_CSR, 32'h1a);
		wake_frame(st, 1);
		chk("power_event_out", 1, power_event_out);
		apb(1'b1, RWF_OFF_WAKE_CSR, 32'h2);
		apb(1'b1, RWF_OFF_MAC_CONTROL, 0);
		go(st, 1'b1);
		chk("resume accept", 1, acc_q.size() == 1 && acc_q[0] === 1'b1);
		chk("no wake when off", 0, wk_n);
		report_and_stop();
	end
endmodule
`default_nettype wire
